// [hdl/asfc_defines.svh]
// Register map, field positions, reset values and timing counts
// Summary of operation
// - Loopback feeds transmitter output into receiver
// - Loopback holds transmit pin at idle high
// - Loopback needs both tx_on and rx_on
// - Open drain drives low only, releases high
// - Short idle counts ones from any one
// - Long idle counts ones after stop bit
// - parity_odd picks odd or even parity
// - Transmitter appends parity, receiver flags mismatch
// - Parity replaces most significant data field bit
// - Long word and parity decode data field
// - Frames are ten or eleven bits only
// - Sleep ends on idle or marked frame
// - Enabled flags raise the interrupt request
// - Status read then data access clears flags
// - tx_on gives pin to transmitter, else released
// - Rising tx_on sends one preamble idle frame
// - Receiver disabled sets no receiver flags
// - Sleeping receiver ignores frames and flags
// - Hardware clears rx_sleep on wakeup
// - Control resets to zero, bit 15 zero
// - Break sends zero frames after current frame
// - Sixteen ticks per bit, three sample majority
`ifndef ASFC_DEFINES_SVH
`define ASFC_DEFINES_SVH
`define ASFC_OFF_BAUD    5'h00
`define ASFC_OFF_CTRL    5'h04
`define ASFC_OFF_STAT    5'h08
`define ASFC_OFF_DATA    5'h0C
`define ASFC_BAUD_RST    13'h0004
`define ASFC_CTRL_RST    15'h0000
`define ASFC_B_LOOP      14
`define ASFC_B_OD        13
`define ASFC_B_ILT       12
`define ASFC_B_PT        11
`define ASFC_B_PE        10
`define ASFC_B_M         9
`define ASFC_B_WAKE      8
`define ASFC_B_TIE       7
`define ASFC_B_TX_DONE_IRQ_EN      6
`define ASFC_B_RIE       5
`define ASFC_B_LINE_QUIET_IRQ_EN      4
`define ASFC_B_TE        3
`define ASFC_B_RE        2
`define ASFC_B_RWU       1
`define ASFC_B_SBK       0
`define ASFC_S_TX_HOLDING_EMPTY      8
`define ASFC_S_TC        7
`define ASFC_S_RX_HOLDING_FULL      6
`define ASFC_S_RAF       5
`define ASFC_S_IDLE      4
`define ASFC_S_OR        3
`define ASFC_S_NF        2
`define ASFC_S_FE        1
`define ASFC_S_PF        0
`define ASFC_LEN_SHORT   4'hA
`define ASFC_LEN_LONG    4'hB
`define ASFC_SUB_LAST    4'hF
`define ASFC_SMP_A       4'h7
`define ASFC_SMP_B       4'h8
`define ASFC_SMP_C       4'h9
`define ASFC_RESP_OK     2'h0
`define ASFC_RESP_ERR    2'h2
`endif

// [hdl/asfc_pkg.sv]
// Types shared by the serial frame control block
package asfc_pkg;
  typedef enum logic [1:0] {
    ASFC_TX_IDLE = 2'h1,
    ASFC_TX_SEND = 2'h2
  } asfc_tx_st_t;
  typedef enum logic [1:0] {
    ASFC_RX_IDLE  = 2'h1,
    ASFC_RX_FRAME = 2'h2
  } asfc_rx_st_t;
  typedef logic [1:0] asfc_resp_t;
endpackage : asfc_pkg

// [hdl/asfc_top.sv]
// Asynchronous serial unit with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "asfc_defines.svh"
module asfc_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [4:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output asfc_pkg::asfc_resp_t   s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [4:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output asfc_pkg::asfc_resp_t   s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rx_pin,
  output logic                   tx_pin_o,
  output logic                   tx_pin_oe,
  output logic                   irq
);
  import asfc_pkg::*;

  function automatic logic [2:0] sel(input logic [4:0] a);
    sel = a[4] ? 3'h4 : {1'b0, a[3:2]};
  endfunction : sel

  function automatic logic par(input logic [8:0] d, input logic m, input logic odd);
    par = (m ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction : par

  function automatic logic [3:0] flen(input logic m);
    flen = m ? `ASFC_LEN_LONG : `ASFC_LEN_SHORT;
  endfunction : flen

  logic [12:0] baud_q;
  logic [14:0] ctrl_q;
  logic [8:0]  tdr_q;
  logic [8:0]  rdr_q;
  logic [8:0]  stat_q;
  logic [8:0]  arm_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [4:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [12:0] div_q;
  logic        tick_q;
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        te_old_q;
  logic        pre_q;
  asfc_tx_st_t tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_sub_q;
  logic [3:0]  tx_idx_q;
  logic [3:0]  tx_len_q;
  logic        tx_bit_q;
  asfc_rx_st_t rx_st_q;
  logic [3:0]  rx_sub_q;
  logic [3:0]  rx_idx_q;
  logic [2:0]  smp_q;
  logic        rx_noise_q;
  logic [8:0]  rx_sh_q;
  logic [3:0]  quiet_q;
  logic        idle_arm_q;

  logic loop_on, rx_in, wr_go, rd_go;
  logic [2:0] wsel, rsel;
  logic stat_rd, data_rd, data_wr;
  logic tx_load_data, tx_frame_end;
  logic maj, bit_end, frame_end, quiet_hit;
  logic set_rx_holding_full, set_or, set_nf, set_fe, set_pf, set_idle, set_raf, clr_raf;
  logic wake_now;
  logic [8:0] fld;
  logic [3:0] nbits;

  assign loop_on = ctrl_q[`ASFC_B_LOOP] & ctrl_q[`ASFC_B_TE] & ctrl_q[`ASFC_B_RE];
  assign rx_in   = loop_on ? tx_bit_q : rx_s2_q;
  assign wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign wsel    = sel(aw_addr_q);
  assign rsel    = sel(s_axi_araddr);
  assign stat_rd = rd_go & (rsel == sel(`ASFC_OFF_STAT));
  assign data_rd = rd_go & (rsel == sel(`ASFC_OFF_DATA));
  assign data_wr = wr_go & (wsel == sel(`ASFC_OFF_DATA)) & w_strb_q[0];

  // Write channel; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 5'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASFC_RESP_OK;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wsel[2] ? `ASFC_RESP_ERR : `ASFC_RESP_OK;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ASFC_RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rsel[2] ? `ASFC_RESP_ERR : `ASFC_RESP_OK;
        case (rsel)
          3'h0:    s_axi_rdata <= {19'h00000, baud_q};
          3'h1:    s_axi_rdata <= {17'h00000, ctrl_q};
          3'h2:    s_axi_rdata <= {23'h000000, stat_q};
          3'h3:    s_axi_rdata <= {23'h000000, rdr_q};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control and baud; hardware clears only rx_sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `ASFC_CTRL_RST;
      baud_q <= `ASFC_BAUD_RST;
      tdr_q  <= 9'h000;
    end else begin
      if (wake_now) ctrl_q[`ASFC_B_RWU] <= 1'b0;
      if (wr_go && wsel == sel(`ASFC_OFF_CTRL)) begin
        if (w_strb_q[0]) ctrl_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) ctrl_q[14:8] <= w_data_q[14:8];
      end
      if (wr_go && wsel == sel(`ASFC_OFF_BAUD)) begin
        if (w_strb_q[0]) baud_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) baud_q[12:8] <= w_data_q[12:8];
      end
      if (data_wr) begin
        tdr_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) tdr_q[8] <= w_data_q[8];
      end
    end
  end

  // Sixteen-times bit-rate tick; divisor zero stops it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 13'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (baud_q == 13'h0000) begin
        div_q <= 13'h0000;
      end else if (div_q >= baud_q - 13'h0001) begin
        div_q  <= 13'h0000;
        tick_q <= 1'b1;
      end else begin
        div_q <= div_q + 13'h0001;
      end
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Data field with parity in its top bit
  always_comb begin
    fld = ctrl_q[`ASFC_B_M] ? tdr_q : {1'b0, tdr_q[7:0]};
    if (ctrl_q[`ASFC_B_PE]) begin
      if (ctrl_q[`ASFC_B_M]) fld[8] = par(tdr_q, 1'b1, ctrl_q[`ASFC_B_PT]);
      else fld[7] = par(tdr_q, 1'b0, ctrl_q[`ASFC_B_PT]);
    end
  end

  assign tx_load_data = (tx_st_q == ASFC_TX_IDLE) & tick_q & ctrl_q[`ASFC_B_TE] & ~pre_q &
                        ~ctrl_q[`ASFC_B_SBK] & ~stat_q[`ASFC_S_TX_HOLDING_EMPTY];
  assign tx_frame_end = (tx_st_q == ASFC_TX_SEND) & tick_q & (tx_sub_q == `ASFC_SUB_LAST) &
                        (tx_idx_q == tx_len_q - 4'h1);

  // Transmitter; preamble and break wait for the frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q  <= ASFC_TX_IDLE;
      tx_sh_q  <= 11'h7FF;
      tx_sub_q <= 4'h0;
      tx_idx_q <= 4'h0;
      tx_len_q <= `ASFC_LEN_SHORT;
      tx_bit_q <= 1'b1;
      te_old_q <= 1'b0;
      pre_q    <= 1'b0;
    end else begin
      te_old_q <= ctrl_q[`ASFC_B_TE];
      if (ctrl_q[`ASFC_B_TE] & ~te_old_q) pre_q <= 1'b1;
      case (tx_st_q)
        ASFC_TX_IDLE: begin
          tx_bit_q <= 1'b1;
          if (tick_q & ctrl_q[`ASFC_B_TE]) begin
            tx_sub_q <= 4'h0;
            tx_idx_q <= 4'h0;
            tx_len_q <= flen(ctrl_q[`ASFC_B_M]);
            if (pre_q) begin
              pre_q    <= 1'b0;
              tx_sh_q  <= 11'h7FF;
              tx_st_q  <= ASFC_TX_SEND;
            end else if (ctrl_q[`ASFC_B_SBK]) begin
              tx_sh_q  <= 11'h000;
              tx_st_q  <= ASFC_TX_SEND;
            end else if (tx_load_data) begin
              tx_sh_q  <= {1'b1, ctrl_q[`ASFC_B_M] ? fld[8] : 1'b1, fld[7:0], 1'b0};
              tx_st_q  <= ASFC_TX_SEND;
            end
          end
        end
        ASFC_TX_SEND: begin
          tx_bit_q <= tx_sh_q[0];
          if (tick_q) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `ASFC_SUB_LAST) begin
              tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
              tx_idx_q <= tx_idx_q + 4'h1;
              if (tx_frame_end) tx_st_q <= ASFC_TX_IDLE;
            end
          end
        end
        default: tx_st_q <= ASFC_TX_IDLE;
      endcase
    end
  end

  // Transmit pin; released while the transmitter does not own it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_o  <= 1'b1;
      tx_pin_oe <= 1'b0;
    end else begin
      if (!ctrl_q[`ASFC_B_TE]) begin
        tx_pin_o  <= 1'b1;
        tx_pin_oe <= 1'b0;
      end else if (ctrl_q[`ASFC_B_OD]) begin
        tx_pin_o  <= 1'b0;
        tx_pin_oe <= ~(tx_bit_q | loop_on);
      end else begin
        tx_pin_o  <= tx_bit_q | loop_on;
        tx_pin_oe <= 1'b1;
      end
    end
  end

  assign maj       = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  assign nbits     = ctrl_q[`ASFC_B_M] ? 4'h9 : 4'h8;
  assign bit_end   = (rx_st_q == ASFC_RX_FRAME) & tick_q & (rx_sub_q == `ASFC_SUB_LAST);
  assign frame_end = bit_end & (rx_idx_q == nbits + 4'h1);
  assign quiet_hit = (rx_st_q == ASFC_RX_IDLE) & tick_q & rx_in & (rx_sub_q == `ASFC_SUB_LAST) &
                     (quiet_q == flen(ctrl_q[`ASFC_B_M]) - 4'h1);

  // Event decode; receiver disabled or asleep sets nothing
  always_comb begin
    logic lastb;
    logic ok;
    lastb    = ctrl_q[`ASFC_B_M] ? rx_sh_q[8] : rx_sh_q[7];
    ok       = ctrl_q[`ASFC_B_RE] & ~ctrl_q[`ASFC_B_RWU];
    wake_now = ctrl_q[`ASFC_B_RE] & ctrl_q[`ASFC_B_RWU] &
               (ctrl_q[`ASFC_B_WAKE] ? (frame_end & lastb) : quiet_hit);
    set_rx_holding_full = frame_end & ok & ~stat_q[`ASFC_S_RX_HOLDING_FULL];
    set_or   = frame_end & ok & stat_q[`ASFC_S_RX_HOLDING_FULL];
    set_nf   = set_rx_holding_full & (rx_noise_q | (smp_q != 3'h0 && smp_q != 3'h7));
    set_fe   = set_rx_holding_full & ~maj;
    set_pf   = set_rx_holding_full & ctrl_q[`ASFC_B_PE] &
               (lastb != par(rx_sh_q, ctrl_q[`ASFC_B_M], ctrl_q[`ASFC_B_PT]));
    set_idle = quiet_hit & ok & idle_arm_q;
    set_raf  = (rx_st_q == ASFC_RX_IDLE) & tick_q & ~rx_in & ok;
    clr_raf  = quiet_hit;
  end

  // Receiver with three mid-bit samples per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q    <= ASFC_RX_IDLE;
      rx_sub_q   <= 4'h0;
      rx_idx_q   <= 4'h0;
      smp_q      <= 3'h7;
      rx_noise_q <= 1'b0;
      rx_sh_q    <= 9'h000;
      quiet_q    <= 4'h0;
      rdr_q      <= 9'h000;
    end else if (!ctrl_q[`ASFC_B_RE]) begin
      rx_st_q  <= ASFC_RX_IDLE;
      rx_sub_q <= 4'h0;
      quiet_q  <= 4'h0;
    end else begin
      if (set_rx_holding_full) rdr_q <= ctrl_q[`ASFC_B_M] ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
      case (rx_st_q)
        ASFC_RX_IDLE: begin
          if (tick_q) begin
            if (!rx_in) begin
              rx_st_q    <= ASFC_RX_FRAME;
              rx_sub_q   <= 4'h1;
              rx_idx_q   <= 4'h0;
              rx_noise_q <= 1'b0;
              quiet_q    <= 4'h0;
            end else begin
              rx_sub_q <= rx_sub_q + 4'h1;
              if (rx_sub_q == `ASFC_SUB_LAST && quiet_q != flen(ctrl_q[`ASFC_B_M]))
                quiet_q <= quiet_q + 4'h1;
            end
          end
        end
        ASFC_RX_FRAME: begin
          if (tick_q) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == `ASFC_SMP_A) smp_q[0] <= rx_in;
            if (rx_sub_q == `ASFC_SMP_B) smp_q[1] <= rx_in;
            if (rx_sub_q == `ASFC_SMP_C) smp_q[2] <= rx_in;
          end
          if (bit_end) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (smp_q != 3'h0 && smp_q != 3'h7 && !frame_end) rx_noise_q <= 1'b1;
            if (!ctrl_q[`ASFC_B_ILT] && maj) quiet_q <= quiet_q + 4'h1;
            else quiet_q <= 4'h0;
            if (rx_idx_q == 4'h0 && maj) begin
              rx_st_q <= ASFC_RX_IDLE; // False start, treated as line noise
              quiet_q <= 4'h0;
            end else if (rx_idx_q != 4'h0 && !frame_end) begin
              rx_sh_q[rx_idx_q - 4'h1] <= maj;
            end
            if (frame_end) begin
              rx_st_q <= ASFC_RX_IDLE;
              if (ctrl_q[`ASFC_B_M] == 1'b0 && ctrl_q[`ASFC_B_ILT] == 1'b0 && maj)
                quiet_q <= quiet_q + 4'h1;
            end
          end
        end
        default: rx_st_q <= ASFC_RX_IDLE;
      endcase
    end
  end

  // Status flags; set beats clear
  always_ff @(posedge aclk) begin
    logic [8:0] clr;
    logic [8:0] set;
    clr = 9'h000;
    set = 9'h000;
    if (data_rd) clr = arm_q & 9'h07F;
    if (data_wr) clr = clr | (arm_q & 9'h180);
    set[`ASFC_S_TX_HOLDING_EMPTY] = tx_load_data;
    set[`ASFC_S_TC]   = (tx_frame_end | (tx_st_q == ASFC_TX_IDLE)) & ~pre_q &
                        ~ctrl_q[`ASFC_B_SBK] & stat_q[`ASFC_S_TX_HOLDING_EMPTY] & ~tx_load_data;
    set[`ASFC_S_RX_HOLDING_FULL] = set_rx_holding_full;
    set[`ASFC_S_RAF]  = set_raf;
    set[`ASFC_S_IDLE] = set_idle;
    set[`ASFC_S_OR]   = set_or;
    set[`ASFC_S_NF]   = set_nf;
    set[`ASFC_S_FE]   = set_fe;
    set[`ASFC_S_PF]   = set_pf;
    if (!aresetn) begin
      stat_q     <= 9'h180;
      arm_q      <= 9'h000;
      idle_arm_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | set;
      if (clr_raf) stat_q[`ASFC_S_RAF] <= 1'b0;
      if (tx_st_q == ASFC_TX_SEND || pre_q) stat_q[`ASFC_S_TC] <= set[`ASFC_S_TC];
      if (stat_rd) arm_q <= stat_q & ~9'h020;
      else arm_q <= arm_q & ~clr;
      if (set_rx_holding_full) idle_arm_q <= 1'b1;
      else if (set_idle) idle_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= (stat_q[`ASFC_S_TX_HOLDING_EMPTY] & ctrl_q[`ASFC_B_TIE]) |
                (stat_q[`ASFC_S_TC] & ctrl_q[`ASFC_B_TX_DONE_IRQ_EN]) |
                (stat_q[`ASFC_S_RX_HOLDING_FULL] & ctrl_q[`ASFC_B_RIE]) |
                (stat_q[`ASFC_S_IDLE] & ctrl_q[`ASFC_B_LINE_QUIET_IRQ_EN]);
  end

endmodule : asfc_top
`default_nettype wire

// [hdl/asfc_top_end.sv]
// Holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb/asfc_chk.sv]
// Port-level assertions for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
`include "asfc_defines.svh"
module asfc_chk (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [4:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [4:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire asfc_pkg::asfc_resp_t s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 tx_pin_o,
  input wire logic                 tx_pin_oe,
  input wire logic                 irq
);
  import asfc_pkg::*;
  // Shadow of the last control write
  logic [4:0]  wa_q;
  logic [31:0] wd_q;
  logic        bv_q;
  logic [14:0] c0_q, c1_q, c2_q;
  logic        steady;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      c0_q <= '0;
      c1_q <= '0;
      c2_q <= '0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_q && wa_q == `ASFC_OFF_CTRL) c0_q <= wd_q[14:0];
      c1_q <= c0_q;
      c2_q <= c1_q;
    end
  end
  // Pin flops lag; judge a settled word
  assign steady = (c0_q == c1_q) && (c1_q == c2_q);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_tx_release: assert property (steady && !c0_q[`ASFC_B_TE] |-> !tx_pin_oe)
    else $error("pin driven with transmitter off");
  chk_od_drive: assert property (steady && c0_q[`ASFC_B_OD] && tx_pin_oe |-> !tx_pin_o)
    else $error("open drain pin driven high");
  chk_loop_idle: assert property (steady && c0_q[`ASFC_B_LOOP] && c0_q[`ASFC_B_TE]
    && c0_q[`ASFC_B_RE] && !c0_q[`ASFC_B_OD] |-> tx_pin_oe && tx_pin_o)
    else $error("loopback pin not idle");
  chk_irq_off: assert property (steady && c0_q[7:4] == 4'h0 |-> !irq)
    else $error("irq with enables clear");
  chk_start_len: assert property ($fell(tx_pin_o) && tx_pin_oe |=> !tx_pin_o [*8])
    else $error("start bit too short");
  chk_w_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  chk_ctrl_b15: assert property (s_rd_take ##0 (s_axi_araddr == `ASFC_OFF_CTRL)
    |=> s_axi_rdata[31:15] == '0)
    else $error("control upper bits not zero");
  chk_unmapped: assert property (s_rd_take ##0 s_axi_araddr[4]
    |=> s_axi_rresp == `ASFC_RESP_ERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
endmodule : asfc_chk
bind asfc_top asfc_chk asfc_chk_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .tx_pin_o, .tx_pin_oe, .irq
);
`default_nettype wire

// [tb/asfc_remote.sv]
// Remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module asfc_remote (
  input  wire logic clk,
  input  wire logic line_in,
  output var logic  line_out
);
  initial line_out = 1'b1;
  // Divisor 1: sixteen clocks a bit
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk) line_out <= bits[i];
    end
  endtask : send
  // Mid-bit samples; wait_n is the high time before start
  task automatic grab(output logic [10:0] bits, output int wait_n);
    bits = '0;
    wait_n = 0;
    while (line_in === 1'b1 && wait_n < 4000) begin
      @(posedge clk);
      wait_n++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      bits[i] = line_in;
      repeat (16) @(posedge clk);
    end
  endtask : grab
endmodule : asfc_remote
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
`include "asfc_defines.svh"
module tb;
  import asfc_pkg::*;
  localparam logic [4:0]  BD = `ASFC_OFF_BAUD, CT = `ASFC_OFF_CTRL;
  localparam logic [4:0]  ST = `ASFC_OFF_STAT, DT = `ASFC_OFF_DATA;
  localparam logic [31:0] TE = 32'h1 << `ASFC_B_TE, RE = 32'h1 << `ASFC_B_RE;
  localparam logic [31:0] PE = 32'h1 << `ASFC_B_PE, PT = 32'h1 << `ASFC_B_PT;
  localparam logic [31:0] OD = 32'h1 << `ASFC_B_OD, LP = 32'h1 << `ASFC_B_LOOP;
  localparam logic [31:0] MW = 32'h1 << `ASFC_B_M, WK = 32'h1 << `ASFC_B_WAKE;
  localparam logic [31:0] RI = 32'h1 << `ASFC_B_RIE, SB = 32'h1 << `ASFC_B_SBK;
  localparam logic [31:0] SL = 32'h1 << `ASFC_B_RWU;
  localparam asfc_resp_t  OK = `ASFC_RESP_OK, ER = `ASFC_RESP_ERR;
  logic        aclk;
  logic        aresetn       = 1'b0;
  logic [4:0]  s_axi_awaddr  = 5'h00;
  logic [4:0]  s_axi_araddr  = 5'h00;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        rx_jam        = 1'b0;
  int          n_mismatch    = 0;
  int          total_checks  = 0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   tx_pin_o, tx_pin_oe, irq, rmt;
  wire logic [31:0] s_axi_rdata;
  wire asfc_resp_t  s_axi_bresp, s_axi_rresp;
  wire logic   rx_pin = rx_jam ? 1'b0 : rmt;
  // Pull-up: a released pin reads high
  wire logic   pin = tx_pin_oe ? tx_pin_o : 1'b1;
  asfc_top asfc_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .tx_pin_o, .tx_pin_oe, .irq
  );
  asfc_remote asfc_remote_inst (.clk(aclk), .line_in(pin), .line_out(rmt));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic to_chk(input int k);
    if (k >= 60) begin
      n_mismatch++;
      complete_run();
    end
  endtask : to_chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input asfc_resp_t er);
    int k;
    logic aw, w, b;
    asfc_resp_t r;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w  = s_axi_wready;
      b  = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      k++;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b && k < 60);
    s_axi_bready <= 1'b0;
    to_chk(k);
    cmp($sformatf("bresp %h", a), {30'h0, er}, {30'h0, r});
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    logic ar, v;
    logic [31:0] d;
    asfc_resp_t r;
    k = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arready;
      v  = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      k++;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v && k < 60);
    s_axi_rready <= 1'b0;
    to_chk(k);
    cmp($sformatf("rdata %h", a), e, d & m);
    cmp($sformatf("rresp %h", a), {30'h0, a[4] ? ER : OK}, {30'h0, r});
  endtask : rc
  function automatic logic [10:0] frm(input logic [8:0] d, input logic m, pe, pt);
    logic [8:0] f;
    f = m ? d : {1'b0, d[7:0]};
    if (pe && m) f[8] = ^f[7:0] ^ pt;
    if (pe && !m) f[7] = ^f[6:0] ^ pt;
    return m ? {1'b1, f, 1'b0} : {2'b11, f[7:0], 1'b0};
  endfunction : frm
  task automatic t_regs();
    rc(CT, 32'hFFFFFFFF, 32'h0);
    rc(ST, 32'h1FF, 32'h180);
    wr(CT, 32'hFFF7, OK);
    rc(CT, 32'hFFFFFFFF, 32'h7FF7);
    wr(CT, 32'h0, OK);
    wr(5'h14, 32'h0, ER);
    rc(5'h10, 32'hFFFFFFFF, 32'h0);
    wr(BD, 32'h1, OK);
    rc(BD, 32'h1FFF, 32'h1);
  endtask : t_regs
  task automatic t_tx();
    logic [10:0] f, mk;
    int n;
    for (int i = 0; i < 8; i++) begin
      mk = i[0] ? 11'h7FF : 11'h3FF;
      wr(CT, TE | ({29'h0, i[2:0]} << `ASFC_B_M) | (i[2] ? OD : 32'h0), OK);
      rc(ST, 32'h100, 32'h100);
      wr(DT, 32'h1B5, OK);
      asfc_remote_inst.grab(f, n);
      cmp("frame", {21'h0, frm(9'h1B5, i[0], i[1], i[2]) & mk}, {21'h0, f & mk});
      // Preamble delays the start bit
      cmp("preamble", 32'h1, {31'h0, n > 120});
      wr(CT, 32'h0, OK);
      @(negedge aclk);
      cmp("tx_pin_oe", 32'h0, {31'h0, tx_pin_oe});
    end
    wr(CT, TE | SB, OK);
    asfc_remote_inst.grab(f, n);
    cmp("break", 32'h0, {21'h0, f & 11'h3FF});
    wr(CT, 32'h0, OK);
  endtask : t_tx
  task automatic t_rx();
    logic [10:0] g;
    g = frm(9'h05A, 1'b0, 1'b1, 1'b1);
    wr(CT, RE | PE | PT | RI, OK);
    asfc_remote_inst.send(g, 10);
    repeat (12) @(negedge aclk);
    cmp("irq", 32'h1, {31'h0, irq});
    rc(ST, 32'h41, 32'h40);
    rc(DT, 32'h7F, 32'h5A);
    repeat (2) @(negedge aclk);
    cmp("irq", 32'h0, {31'h0, irq});
    asfc_remote_inst.send(g ^ 11'h100, 10);
    repeat (12) @(negedge aclk);
    rc(ST, 32'h41, 32'h41);
    rc(DT, 32'h7F, 32'h5A);
    wr(CT, PE, OK);
    asfc_remote_inst.send(g, 10);
    repeat (12) @(negedge aclk);
    rc(ST, 32'h4F, 32'h0);
  endtask : t_rx
  task automatic t_loop();
    int k;
    k = 0;
    rx_jam <= 1'b1;
    wr(CT, LP | TE | RE, OK);
    rc(ST, 32'h100, 32'h100);
    wr(DT, 32'h3C, OK);
    repeat (400) begin
      @(negedge aclk);
      if (pin !== 1'b1) k++;
    end
    cmp("pin low count", 32'h0, k);
    rc(ST, 32'h40, 32'h40);
    rc(DT, 32'hFF, 32'h3C);
    wr(CT, 32'h0, OK);
    rx_jam <= 1'b0;
  endtask : t_loop
  task automatic t_sleep();
    wr(CT, RE | MW | WK | SL, OK);
    asfc_remote_inst.send(frm(9'h055, 1'b1, 1'b0, 1'b0), 11);
    repeat (12) @(negedge aclk);
    rc(CT, SL, SL);
    rc(ST, 32'h40, 32'h0);
    asfc_remote_inst.send(frm(9'h155, 1'b1, 1'b0, 1'b0), 11);
    repeat (12) @(negedge aclk);
    rc(CT, SL, 32'h0);
    rc(ST, 32'h40, 32'h0);
  endtask : t_sleep
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_loop();
    t_sleep();
    complete_run();
  end
endmodule : tb
`default_nettype wire
